// ### vas_top.v
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`include "vas_map.vh"

// What this block does
// - Host 16/32-bit writes to the window become successive single-byte writes.
// - Host 16/32-bit reads are assembled from successive single-byte reads.
// - Sequencer itself generates address bits 1:0 for each byte step.
// - Byte write path raises no trap; undisplayed writes stay silent.
// - Writes to enabled, displayed areas raise the management interrupt.
// - Byte write: rotate, write mode, ALU, bit mask, plane enables to 32 bits.
// - Byte read: plane select or colour compare to one byte; never traps.
// - Window A0000h-AFFFFh relocated via base, odd/even and chain-four modes.
// - Display memory is 64K words of 32 bits, one byte per plane.
// - Base is 256 KB aligned and concatenated, no adder.
// - Range enable bits 0..2 cover A0000h, B0000h and B8000h ranges.
// - Range enable register resets to zero, trapping off.
// - Region mask bit n enables the 2 KB slice at A0000h plus n*2 KB.
// - With no range enabled the region mask is ignored, no memory trap.
// - I/O 3B0h, 3C0h, 3D0h ranges trap, each with its own enable.
// - Processor trap fires at decode time, one cycle after the access.
module vas_top #(
	parameter MEM_AW = 32
) (
	input wire ref_clk_i, // Core clock, 50 MHz.
	input wire rst_i, // Synchronous reset, active high.
	input wire [7:0] avs_address_i, // Register word index.
	input wire avs_read_i, // Register read request.
	input wire avs_write_i, // Register write request.
	input wire [31:0] avs_writedata_i, // Register write data.
	input wire [3:0] avs_byteenable_i, // Register byte lanes.
	output reg [31:0] avs_readdata_o, // Register read data.
	output reg avs_waitrequest_o, // Low for the accepting cycle.
	input wire host_req_i, // Host window access, held until done.
	input wire host_we_i, // Host access is a write.
	input wire [19:0] host_addr_i, // Host byte address in the window.
	input wire [1:0] host_size_i, // 0 byte, 1 word, 2 dword.
	input wire [31:0] host_wdata_i, // Host write data, lane aligned.
	output reg host_done_o, // One-cycle completion pulse.
	output reg [31:0] host_rdata_o, // Assembled read data.
	output reg mem_req_o, // Memory request, held until ack.
	output reg mem_we_o, // Memory request is a write.
	output reg [MEM_AW-1:0] mem_addr_o, // Memory byte address of the word.
	output reg [31:0] mem_wdata_o, // Four-plane write word.
	output reg [3:0] mem_plane_en_o, // Plane write enables.
	input wire mem_ack_i, // Memory completion pulse.
	input wire [31:0] mem_rdata_i, // Memory read word, valid with ack.
	input wire cpu_acc_valid_i, // Processor access at decode stage.
	input wire cpu_acc_we_i, // Processor access is a write.
	input wire cpu_acc_io_i, // Processor access is I/O.
	input wire [19:0] cpu_acc_addr_i, // Physical or I/O address.
	output reg system_management_interrupt_o, // One-cycle trap pulse.
	output reg irq_o // Level interrupt from status and mask.
);
	// ------------------------------------------------------------------
	// Sequencer states.
	// ------------------------------------------------------------------
	localparam S_IDLE = 2'd0;
	localparam S_ISSUE = 2'd1;
	localparam S_WAIT = 2'd2;
	localparam S_DONE = 2'd3;
	reg [7:0] trap_range_enable;
	reg [31:0] trap_region_mask;
	reg [31:0] write_ctl;
	reg [31:0] read_ctl;
	reg [MEM_AW-19:0] mem_base;
	reg [31:0] latch;
	reg [2:0] irq_status;
	reg [2:0] irq_mask;
	reg [2:0] bus_io_trap_enables;
	reg [1:0] state;
	reg [1:0] lane;
	reg [1:0] left;
	reg [31:0] acc_rdata;
	reg [19:0] byte_addr;
	reg [3:0] plane_sel;
	reg [15:0] word_idx;
	reg [1:0] read_plane;
	reg [7:0] rd_byte;
	reg [31:0] wr_word;
	reg [2:0] irq_set;
	reg [31:0] next_readdata;
	reg trap_hit;
	wire reg_wr;
	wire [7:0] host_byte;
	// ------------------------------------------------------------------
	// Helper functions.
	// ------------------------------------------------------------------
	// Merges write data into a register under Avalon byte enables.
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					be_merge[i*8 +: 8] = wd[i*8 +: 8];
				end
			end
		end
	endfunction

	// Decides whether a processor access must be trapped.
	function trap_check;
		input we;
		input io;
		input [19:0] a;
		input [7:0] ren;
		input [31:0] rmask;
		input [2:0] ioen;
		begin
			trap_check = 1'b0;
			if (io) begin
				if (a[19:4] == {4'h0, `VAS_IO_MONO}) begin
					trap_check = ioen[0];
				end else if (a[19:4] == {4'h0, `VAS_IO_ATTR}) begin
					trap_check = ioen[1];
				end else if (a[19:4] == {4'h0, `VAS_IO_COLOR}) begin
					trap_check = ioen[2];
				end
			end else if (we) begin
				// Range enable gates everything, so a zero enable set
				// leaves the region mask without effect.
				if (a[19:16] == `VAS_RANGE_A) begin
					trap_check = ren[0] & rmask[a[15:11]];
				end else if (a[19:16] == `VAS_RANGE_B) begin
					trap_check = a[15] ? ren[2] : ren[1];
				end
			end
		end
	endfunction

	// Rotates a byte right by 0 to 7 places.
	function [7:0] rot_right;
		input [7:0] d;
		input [2:0] n;
		reg [15:0] t;
		begin
			t = {d, d} >> n;
			rot_right = t[7:0];
		end
	endfunction
	// ------------------------------------------------------------------
	// Address generation.
	// ------------------------------------------------------------------
	assign host_byte = host_wdata_i[lane*8 +: 8];

	// Maps the current byte step onto a word index and planes.
	always @* begin
		byte_addr = {host_addr_i[19:2], lane} - `VAS_WIN_BASE;
		if (read_ctl[`VAS_RC_CHAIN4]) begin
			word_idx = {2'b00, byte_addr[15:2]};
			plane_sel = 4'b0001 << byte_addr[1:0];
			read_plane = byte_addr[1:0];
		end else if (read_ctl[`VAS_RC_ODDEVEN]) begin
			word_idx = {1'b0, byte_addr[15:1]};
			plane_sel = byte_addr[0] ? 4'b1010 : 4'b0101;
			read_plane = {read_ctl[9], byte_addr[0]};
		end else begin
			word_idx = byte_addr[15:0];
			plane_sel = 4'b1111;
			read_plane = read_ctl[`VAS_RC_MAPSEL];
		end
	end
	// ------------------------------------------------------------------
	// Byte write path.
	// ------------------------------------------------------------------
	// Builds the 32-bit plane word for one host byte; never traps.
	always @* begin : wr_path
		reg [7:0] rot;
		reg [7:0] mask;
		reg [31:0] src;
		reg [31:0] alu;
		integer b;
		b = 0;
		rot = rot_right(host_byte, write_ctl[`VAS_WC_ROT]);
		mask = write_ctl[`VAS_WC_BITMASK];
		src = 32'h0000_0000;
		alu = 32'h0000_0000;
		wr_word = 32'h0000_0000;
		if (write_ctl[`VAS_WC_W3]) begin
			mask = mask & rot;
		end
		for (b = 0; b < 4; b = b + 1) begin
			if (write_ctl[`VAS_WC_W2]) begin
				src[b*8 +: 8] = {8{host_byte[b]}};
			end else if (write_ctl[`VAS_WC_W3] | write_ctl[12 + b]) begin
				src[b*8 +: 8] = {8{write_ctl[8 + b]}};
			end else begin
				src[b*8 +: 8] = rot;
			end
		end
		case (write_ctl[`VAS_WC_ALU])
			`VAS_ALU_AND: alu = src & latch;
			`VAS_ALU_OR: alu = src | latch;
			`VAS_ALU_XOR: alu = src ^ latch;
			default: alu = src;
		endcase
		// A zero mask bit keeps the latched bit in every plane.
		for (b = 0; b < 4; b = b + 1) begin
			wr_word[b*8 +: 8] = (alu[b*8 +: 8] & mask) |
				(latch[b*8 +: 8] & ~mask);
		end
	end
	// ------------------------------------------------------------------
	// Byte read path.
	// ------------------------------------------------------------------
	// Reduces a memory word to one byte by plane select or compare.
	always @* begin : rd_path
		integer n;
		n = 0;
		rd_byte = mem_rdata_i[read_plane*8 +: 8];
		if (read_ctl[`VAS_RC_MODE1]) begin
			for (n = 0; n < 8; n = n + 1) begin
				rd_byte[n] = ~|(({mem_rdata_i[24 + n], mem_rdata_i[16 + n],
					mem_rdata_i[8 + n], mem_rdata_i[n]} ^
					read_ctl[`VAS_RC_CC]) & read_ctl[`VAS_RC_CARE]);
			end
		end
	end
	// ------------------------------------------------------------------
	// Access sequencer.
	// ------------------------------------------------------------------
	// Steps through byte lanes, one memory operation per byte.
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= S_IDLE;
			lane <= 2'b00;
			left <= 2'b00;
			acc_rdata <= `VAS_RST_WORD;
			host_done_o <= 1'b0;
			host_rdata_o <= `VAS_RST_WORD;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= {MEM_AW{1'b0}};
			mem_wdata_o <= `VAS_RST_WORD;
			mem_plane_en_o <= 4'h0;
			latch <= `VAS_RST_WORD;
		end else begin
			host_done_o <= 1'b0;
			case (state)
				S_IDLE: begin
					if (host_req_i && !host_done_o) begin
						lane <= host_addr_i[1:0];
						acc_rdata <= `VAS_RST_WORD;
						case (host_size_i)
							`VAS_SIZE_WORD: left <= 2'd1;
							`VAS_SIZE_DWORD: left <= 2'd3;
							default: left <= 2'd0;
						endcase
						state <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					mem_req_o <= 1'b1;
					mem_we_o <= host_we_i;
					mem_addr_o <= {mem_base, word_idx, 2'b00};
					mem_wdata_o <= wr_word;
					mem_plane_en_o <= host_we_i ?
						(plane_sel & write_ctl[`VAS_WC_MAPMASK]) : 4'h0;
					state <= S_WAIT;
				end
				S_WAIT: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						if (!mem_we_o) begin
							latch <= mem_rdata_i;
							acc_rdata[lane*8 +: 8] <= rd_byte;
						end
						if (left == 2'd0) begin
							state <= S_DONE;
						end else begin
							left <= left - 2'd1;
							lane <= lane + 2'd1;
							state <= S_ISSUE;
						end
					end
				end
				S_DONE: begin
					host_done_o <= 1'b1;
					host_rdata_o <= acc_rdata;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
			if (reg_wr && avs_address_i == `VAS_IDX_LATCH) begin
				latch <= be_merge(latch, avs_writedata_i, avs_byteenable_i);
			end
		end
	end
	// ------------------------------------------------------------------
	// Processor-side trap.
	// ------------------------------------------------------------------
	// Evaluates the access as it is decoded and pulses next cycle.
	always @* begin
		trap_hit = cpu_acc_valid_i & trap_check(cpu_acc_we_i, cpu_acc_io_i,
			cpu_acc_addr_i, trap_range_enable, trap_region_mask,
			bus_io_trap_enables);
	end
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			system_management_interrupt_o <= 1'b0;
		end else begin
			system_management_interrupt_o <= trap_hit;
		end
	end
	// ------------------------------------------------------------------
	// Register bus slave.
	// ------------------------------------------------------------------
	assign reg_wr = avs_write_i & ~avs_waitrequest_o;
	// Selects read data; unmapped indices read as zero.
	always @* begin
		case (avs_address_i)
			`VAS_IDX_RANGE_EN: next_readdata = {24'h00_0000, trap_range_enable};
			`VAS_IDX_REGION_MASK: next_readdata = trap_region_mask;
			`VAS_IDX_WRITE_CTL: next_readdata = write_ctl;
			`VAS_IDX_READ_CTL: next_readdata = read_ctl;
			`VAS_IDX_MEM_BASE: next_readdata = {mem_base, 18'h0_0000};
			`VAS_IDX_LATCH: next_readdata = latch;
			`VAS_IDX_IRQ_STATUS: next_readdata = {29'h0, irq_status};
			`VAS_IDX_IRQ_MASK: next_readdata = {29'h0, irq_mask};
			`VAS_IDX_IO_TRAP_EN: next_readdata = {29'h0, bus_io_trap_enables};
			default: next_readdata = `VAS_RST_WORD;
		endcase
	end

	// Takes a request in two cycles: wait drops, then it is accepted.
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= `VAS_RST_WORD;
			trap_range_enable <= `VAS_RST_RANGE_EN;
			trap_region_mask <= `VAS_RST_WORD;
			write_ctl <= `VAS_RST_WORD;
			read_ctl <= `VAS_RST_WORD;
			mem_base <= {(MEM_AW-18){1'b0}};
			irq_mask <= `VAS_RST_IRQ;
			bus_io_trap_enables <= `VAS_RST_IO_EN;
		end else begin
			if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b0;
				avs_readdata_o <= next_readdata;
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
			if (reg_wr) begin
				case (avs_address_i)
					`VAS_IDX_RANGE_EN: begin
						if (avs_byteenable_i[0]) begin
							trap_range_enable <= {5'h00,
								avs_writedata_i[2:0]};
						end
					end
					`VAS_IDX_REGION_MASK: trap_region_mask <= be_merge(
						trap_region_mask, avs_writedata_i,
						avs_byteenable_i);
					`VAS_IDX_WRITE_CTL: write_ctl <= be_merge(write_ctl,
						avs_writedata_i, avs_byteenable_i) & `VAS_WC_USED;
					`VAS_IDX_READ_CTL: read_ctl <= be_merge(read_ctl,
						avs_writedata_i, avs_byteenable_i) & `VAS_RC_USED;
					`VAS_IDX_MEM_BASE: mem_base <= avs_writedata_i[MEM_AW-1:18];
					`VAS_IDX_IRQ_MASK: irq_mask <= avs_writedata_i[2:0];
					`VAS_IDX_IO_TRAP_EN:
						bus_io_trap_enables <= avs_writedata_i[2:0];
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status.
	// ------------------------------------------------------------------
	// Sticky status with write-one-to-clear; a new event beats the clear.
	always @* begin
		irq_set = 3'h0;
		irq_set[`VAS_IRQ_MEM] = trap_hit & ~cpu_acc_io_i;
		irq_set[`VAS_IRQ_IO] = trap_hit & cpu_acc_io_i;
		irq_set[`VAS_IRQ_HOST] = (state == S_DONE);
	end

	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_status <= `VAS_RST_IRQ;
			irq_o <= 1'b0;
		end else begin
			if (reg_wr && avs_address_i == `VAS_IDX_IRQ_STATUS) begin
				irq_status <= (irq_status & ~avs_writedata_i[2:0]) | irq_set;
			end else begin
				irq_status <= irq_status | irq_set;
			end
			irq_o <= |(irq_status & irq_mask);
		end
	end

endmodule // vas_top

// ### vas_map.vh
`ifndef VAS_MAP_VH
`define VAS_MAP_VH
// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index).
// ----------------------------------------------------------------------
`define VAS_IDX_RANGE_EN 8'hB9
`define VAS_IDX_REGION_MASK 8'hBA
`define VAS_IDX_WRITE_CTL 8'hC0
`define VAS_IDX_READ_CTL 8'hC1
`define VAS_IDX_MEM_BASE 8'hC2
`define VAS_IDX_LATCH 8'hC3
`define VAS_IDX_IRQ_STATUS 8'hC4
`define VAS_IDX_IRQ_MASK 8'hC5
`define VAS_IDX_IO_TRAP_EN 8'hC6
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define VAS_RST_RANGE_EN 8'h00
`define VAS_RST_WORD 32'h0000_0000
`define VAS_RST_IO_EN 3'h0
`define VAS_RST_IRQ 3'h0
// ----------------------------------------------------------------------
// Write control fields.
// ----------------------------------------------------------------------
`define VAS_WC_BITMASK 7:0
`define VAS_WC_SR 11:8
`define VAS_WC_SRE 15:12
`define VAS_WC_ROT 18:16
`define VAS_WC_W2 19
`define VAS_WC_W3 20
`define VAS_WC_ALU 22:21
`define VAS_WC_MAPMASK 27:24
`define VAS_WC_USED 32'h0FFF_FFFF
// ----------------------------------------------------------------------
// Read control fields.
// ----------------------------------------------------------------------
`define VAS_RC_CC 3:0
`define VAS_RC_CARE 7:4
`define VAS_RC_MAPSEL 9:8
`define VAS_RC_MODE1 10
`define VAS_RC_ODDEVEN 11
`define VAS_RC_CHAIN4 12
`define VAS_RC_USED 32'h0000_1FFF
// ----------------------------------------------------------------------
// Raster operations, host sizes, window and trap ranges.
// ----------------------------------------------------------------------
`define VAS_ALU_COPY 2'h0
`define VAS_ALU_AND 2'h1
`define VAS_ALU_OR 2'h2
`define VAS_ALU_XOR 2'h3
`define VAS_SIZE_BYTE 2'h0
`define VAS_SIZE_WORD 2'h1
`define VAS_SIZE_DWORD 2'h2
`define VAS_WIN_BASE 20'hA_0000
`define VAS_RANGE_A 4'hA
`define VAS_RANGE_B 4'hB
`define VAS_IO_MONO 12'h03B
`define VAS_IO_ATTR 12'h03C
`define VAS_IO_COLOR 12'h03D
`define VAS_IRQ_MEM 0
`define VAS_IRQ_IO 1
`define VAS_IRQ_HOST 2
`endif

// ### vas_checker.sv
`timescale 1ns/10ps
module vas_checker #(
	parameter MEM_AW = 32
) (
	input wire ref_clk_i, // Core clock.
	input wire rst_i, // Synchronous reset.
	input wire avs_read_i, // Register read strobe.
	input wire avs_write_i, // Register write strobe.
	input wire avs_waitrequest_o, // Register wait.
	input wire host_req_i, // Host window request.
	input wire host_done_o, // Host completion pulse.
	input wire mem_req_o, // Memory request.
	input wire mem_ack_i, // Memory ack.
	input wire [MEM_AW-1:0] mem_addr_o, // Memory address.
	input wire [31:0] mem_wdata_o, // Memory write word.
	input wire cpu_acc_valid_i, // Decoded processor access.
	input wire cpu_acc_we_i, // Access is a write.
	input wire cpu_acc_io_i, // Access is I/O.
	input wire [19:0] cpu_acc_addr_i, // Access address.
	input wire system_management_interrupt_o, // Trap pulse.
	input wire irq_o // Level interrupt.
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// A trap pulse needs a decoded access on the edge before it.
	a_smi_cause: assert property (
		system_management_interrupt_o |-> $past(cpu_acc_valid_i))
		else $error("Trap pulse without a decoded access.");
	a_read_silent: assert property (
		cpu_acc_valid_i && !cpu_acc_we_i && !cpu_acc_io_i
		|=> !system_management_interrupt_o)
		else $error("Memory read raised a trap.");
	a_window_only: assert property (
		cpu_acc_valid_i && !cpu_acc_io_i && cpu_acc_addr_i[19:17] != 3'h5
		|=> !system_management_interrupt_o)
		else $error("Trap outside the display window.");
	a_io_range: assert property (
		cpu_acc_valid_i && cpu_acc_io_i && (cpu_acc_addr_i[19:4] < 16'h003B
		|| cpu_acc_addr_i[19:4] > 16'h003D) |=> !system_management_interrupt_o)
		else $error("Trap for an I/O port outside the ranges.");
	a_mem_hold: assert property (
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
		&& $stable(mem_wdata_o))
		else $error("Memory request changed before ack.");
	a_mem_release: assert property (
		mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("Memory request held after ack.");
	a_word_align: assert property (
		mem_req_o |-> mem_addr_o[1:0] == 2'h0)
		else $error("Memory address not word aligned.");
	a_mem_from_host: assert property (
		$rose(mem_req_o) |-> host_req_i)
		else $error("Memory request without a host access.");
	a_done_last: assert property (
		host_done_o |-> !mem_req_o ##1 !host_done_o)
		else $error("Completion overlaps a byte or lasts too long.");
	a_wait_one: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("Register access not answered after one wait.");
	// Main scenarios seen.
	c_trap: cover property (system_management_interrupt_o);
	c_done: cover property (host_done_o);
	c_irq: cover property (irq_o);
endmodule // vas_checker

bind vas_top vas_checker #(.MEM_AW(MEM_AW)) i_chk (.ref_clk_i, .rst_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .host_req_i,
	.host_done_o, .mem_req_o, .mem_ack_i, .mem_addr_o, .mem_wdata_o,
	.cpu_acc_valid_i, .cpu_acc_we_i, .cpu_acc_io_i, .cpu_acc_addr_i,
	.system_management_interrupt_o, .irq_o);

// ### vas_mem_model.sv
`timescale 1ns/10ps
module vas_mem_model #(
	parameter MEM_AW = 32
) (
	input wire ref_clk_i, // Core clock.
	input wire rst_i, // Synchronous reset.
	input wire slow_i, // Insert wait cycles before each ack.
	input wire mem_req_i, // Request from the block.
	input wire mem_we_i, // Request is a write.
	input wire [MEM_AW-1:0] mem_addr_i, // Word byte address.
	input wire [31:0] mem_wdata_i, // Four-plane write word.
	input wire [3:0] mem_plane_en_i, // Plane enables.
	output logic mem_ack_o, // One-cycle completion pulse.
	output logic [31:0] mem_rdata_o, // Read word with ack.
	output logic [7:0] wr_cnt_o, // Writes served.
	output logic [7:0] rd_cnt_o, // Reads served.
	output logic [MEM_AW-1:0] last_addr_o, // Last served address.
	output logic [31:0] last_wdata_o // Last written word.
);
	logic [31:0] mem [0:65535];
	logic [2:0] wait_cnt;
	integer i;
	// Serves each held request once; read data toggles when not valid.
	always @(posedge ref_clk_i) begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (rst_i) begin
			wait_cnt <= 3'h0;
			wr_cnt_o <= 8'h00;
			rd_cnt_o <= 8'h00;
			mem_rdata_o <= 32'h0000_0000;
		end else if (mem_req_i && !mem_ack_o) begin
			if (slow_i && wait_cnt != 3'h3) begin
				wait_cnt <= wait_cnt + 3'h1;
			end else begin
				wait_cnt <= 3'h0;
				mem_ack_o <= 1'b1;
				last_addr_o <= mem_addr_i;
				if (mem_we_i) begin
					wr_cnt_o <= wr_cnt_o + 8'h01;
					last_wdata_o <= mem_wdata_i;
					for (i = 0; i < 4; i++) begin
						if (mem_plane_en_i[i]) begin
							mem[mem_addr_i[17:2]][i*8 +: 8] <= mem_wdata_i[i*8 +: 8];
						end
					end
				end else begin
					rd_cnt_o <= rd_cnt_o + 8'h01;
					mem_rdata_o <= mem[mem_addr_i[17:2]];
				end
			end
		end
	end
endmodule // vas_mem_model

// ### tb.sv
`timescale 1ns/10ps
`include "vas_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic host_req_i = 1'b0;
	logic host_we_i = 1'b0;
	logic [19:0] host_addr_i = 20'h0_0000;
	logic [1:0] host_size_i = 2'h0;
	logic [31:0] host_wdata_i = 32'h0000_0000;
	logic cpu_acc_valid_i = 1'b0;
	logic cpu_acc_we_i = 1'b0;
	logic cpu_acc_io_i = 1'b0;
	logic [19:0] cpu_acc_addr_i = 20'h0_0000;
	logic slow = 1'b0;
	wire [31:0] avs_readdata_o, host_rdata_o, mem_wdata_o, mem_rdata_i;
	wire [31:0] mem_addr_o, last_addr, last_wdata;
	wire avs_waitrequest_o, host_done_o, mem_req_o, mem_we_o, mem_ack_i;
	wire system_management_interrupt_o, irq_o;
	wire [3:0] mem_plane_en_o;
	wire [7:0] wr_cnt, rd_cnt;
	int bad_count = 0;
	int compares = 0;
	logic [31:0] rd;
	vas_top i_dut (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
		.avs_readdata_o, .avs_waitrequest_o, .host_req_i, .host_we_i,
		.host_addr_i, .host_size_i, .host_wdata_i, .host_done_o,
		.host_rdata_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
		.mem_plane_en_o, .mem_ack_i, .mem_rdata_i, .cpu_acc_valid_i,
		.cpu_acc_we_i, .cpu_acc_io_i, .cpu_acc_addr_i,
		.system_management_interrupt_o, .irq_o);
	vas_mem_model i_mem (.ref_clk_i, .rst_i, .slow_i(slow),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .mem_plane_en_i(mem_plane_en_o),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .wr_cnt_o(wr_cnt),
		.rd_cnt_o(rd_cnt), .last_addr_o(last_addr), .last_wdata_o(last_wdata));
	// Free-running core clock.
	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic summarize;
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic reg_acc(input logic we, input logic [7:0] idx,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		avs_address_i <= idx;
		avs_writedata_i <= d;
		avs_read_i <= !we;
		avs_write_i <= we;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (n == 50) begin
			bad_count++;
			summarize();
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
		reg_acc(1'b0, idx, 32'h0000_0000);
		`CHK(rd, e)
	endtask
	task automatic host(input logic we, input logic [19:0] a,
		input logic [1:0] sz, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		host_we_i <= we;
		host_addr_i <= a;
		host_size_i <= sz;
		host_wdata_i <= d;
		host_req_i <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge ref_clk_i);
			if (host_done_o === 1'b1) break;
		end
		if (n == 200) begin
			bad_count++;
			summarize();
		end
		rd = host_rdata_o;
		host_req_i <= 1'b0;
	endtask
	task automatic cpu(input logic io, input logic we, input logic [19:0] a,
		input logic e);
		@(posedge ref_clk_i);
		cpu_acc_valid_i <= 1'b1;
		cpu_acc_io_i <= io;
		cpu_acc_we_i <= we;
		cpu_acc_addr_i <= a;
		@(posedge ref_clk_i);
		cpu_acc_valid_i <= 1'b0;
		#1;
		`CHK(system_management_interrupt_o, e)
	endtask
	task automatic irq_chk(input logic [7:0] idx, input logic [31:0] d,
		input logic e);
		reg_acc(1'b1, idx, d);
		repeat (2) @(posedge ref_clk_i);
		#1;
		`CHK(irq_o, e)
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rchk(`VAS_IDX_RANGE_EN, 32'h0000_0000);
		rchk(8'h10, 32'h0000_0000);
		reg_acc(1'b1, `VAS_IDX_RANGE_EN, 32'h0000_00FF);
		rchk(`VAS_IDX_RANGE_EN, 32'h0000_0007);
		reg_acc(1'b1, `VAS_IDX_WRITE_CTL, 32'h0F00_00FF);
		reg_acc(1'b1, `VAS_IDX_MEM_BASE, 32'h0004_0000);
		host(1'b1, 20'hA_0000, `VAS_SIZE_DWORD, 32'h4433_2211);
		`CHK(wr_cnt, 8'h04)
		`CHK(last_wdata, 32'h4444_4444)
		`CHK(last_addr[31:18], 14'h0001)
		slow <= 1'b1;
		host(1'b0, 20'hA_0000, `VAS_SIZE_DWORD, 32'h0000_0000);
		`CHK(rd, 32'h4433_2211)
		`CHK(rd_cnt, 8'h04)
		host(1'b1, 20'hA_0006, `VAS_SIZE_WORD, 32'hBBAA_0000);
		`CHK(wr_cnt, 8'h06)
		host(1'b0, 20'hA_0006, `VAS_SIZE_WORD, 32'h0000_0000);
		`CHK(rd[31:16], 16'hBBAA)
		slow <= 1'b0;
		reg_acc(1'b1, `VAS_IDX_WRITE_CTL, 32'h0F04_00FF);
		host(1'b1, 20'hA_0010, `VAS_SIZE_BYTE, 32'h0000_0012);
		`CHK(last_wdata, 32'h2121_2121)
		// Raster operation against the latch, then write mode two.
		rchk(`VAS_IDX_LATCH, 32'hBBBB_BBBB);
		reg_acc(1'b1, `VAS_IDX_LATCH, 32'h0F0F_F0F0);
		reg_acc(1'b1, `VAS_IDX_WRITE_CTL, 32'h0F60_000F);
		host(1'b1, 20'hA_0020, `VAS_SIZE_BYTE, 32'h0000_00FF);
		`CHK(last_wdata, 32'h0000_FFFF)
		reg_acc(1'b1, `VAS_IDX_WRITE_CTL, 32'h0F08_00FF);
		host(1'b1, 20'hA_0024, `VAS_SIZE_BYTE, 32'h0000_0005);
		`CHK(last_wdata, 32'h00FF_00FF)
		// Chain-four addressing, then read mode one on the same word.
		reg_acc(1'b1, `VAS_IDX_WRITE_CTL, 32'h0F00_00FF);
		reg_acc(1'b1, `VAS_IDX_READ_CTL, 32'h0000_1000);
		host(1'b1, 20'hA_0040, `VAS_SIZE_DWORD, 32'h4433_2211);
		`CHK(last_addr, 32'h0004_0040)
		host(1'b0, 20'hA_0040, `VAS_SIZE_DWORD, 32'h0000_0000);
		`CHK(rd, 32'h4433_2211)
		reg_acc(1'b1, `VAS_IDX_READ_CTL, 32'h0000_04F5);
		host(1'b0, 20'hA_0010, `VAS_SIZE_BYTE, 32'h0000_0000);
		`CHK(rd, 32'h0000_0011)
		reg_acc(1'b1, `VAS_IDX_RANGE_EN, 32'h0000_0001);
		reg_acc(1'b1, `VAS_IDX_REGION_MASK, 32'h0000_0002);
		rchk(`VAS_IDX_REGION_MASK, 32'h0000_0002);
		cpu(1'b0, 1'b1, 20'hA_0800, 1'b1);
		cpu(1'b0, 1'b1, 20'hA_0000, 1'b0);
		cpu(1'b0, 1'b0, 20'hA_0800, 1'b0);
		cpu(1'b0, 1'b1, 20'hB_0000, 1'b0);
		reg_acc(1'b1, `VAS_IDX_RANGE_EN, 32'h0000_0006);
		cpu(1'b0, 1'b1, 20'hB_0000, 1'b1);
		cpu(1'b0, 1'b1, 20'hB_8000, 1'b1);
		cpu(1'b0, 1'b1, 20'hA_0800, 1'b0);
		reg_acc(1'b1, `VAS_IDX_RANGE_EN, 32'h0000_0000);
		cpu(1'b0, 1'b1, 20'hB_8000, 1'b0);
		reg_acc(1'b1, `VAS_IDX_IO_TRAP_EN, 32'h0000_0001);
		cpu(1'b1, 1'b0, 20'h0_03B4, 1'b1);
		cpu(1'b1, 1'b1, 20'h0_03C4, 1'b0);
		reg_acc(1'b1, `VAS_IDX_IO_TRAP_EN, 32'h0000_0007);
		cpu(1'b1, 1'b1, 20'h0_03D4, 1'b1);
		rchk(`VAS_IDX_IRQ_STATUS, 32'h0000_0007);
		irq_chk(`VAS_IDX_IRQ_MASK, 32'h0000_0000, 1'b0);
		irq_chk(`VAS_IDX_IRQ_MASK, 32'h0000_0001, 1'b1);
		irq_chk(`VAS_IDX_IRQ_STATUS, 32'h0000_0001, 1'b0);
		rchk(`VAS_IDX_IRQ_STATUS, 32'h0000_0006);
		summarize();
	end
endmodule // tb
